//--- pid_limits.v
// Loop limit stage: deadband, setpoint and control clamps, offset, error status and pulse output over APB.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "pid_limits_regs.vh"
module pid_limits #(
  parameter integer TENTH_COUNT = `TENTH_SEC_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        loop_update,
  input  wire [15:0] computed_value,
  output reg  [15:0] loop_error_out,
  output reg  [15:0] setpoint_used,
  output reg  [11:0] control_value,
  output reg         saturated,
  output wire        pulse_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg  [15:0] deadband_value;
  reg  [15:0] setpoint_low_limit;
  reg  [15:0] setpoint_high_limit;
  reg  [15:0] control_low_limit;
  reg  [15:0] control_high_limit;
  reg  [15:0] control_offset;
  reg  [15:0] loop_error;
  reg  [15:0] pulse_cycle_time;
  reg  [15:0] setpoint_value;
  reg  [15:0] process_value;
  reg  [11:0] manual_value;
  reg         auto_mode;
  reg         pulse_enable;

  wire [9:0]  word_index;
  wire        addr_ok;
  wire        wr_en;
  reg         mapped;

  assign word_index = paddr[11:2];
  assign addr_ok    = (paddr[1:0] == 2'b00);
  assign pready     = 1'b1;
  assign wr_en      = psel & penable & pwrite;
  assign pslverr    = psel & penable & ~(mapped & addr_ok);

  always @*
  begin
    case (word_index)
      {2'b00, `IDX_DEADBAND}, {2'b00, `IDX_SP_LOW}, {2'b00, `IDX_SP_HIGH},
      {2'b00, `IDX_CV_LOW}, {2'b00, `IDX_CV_HIGH}, {2'b00, `IDX_CV_OFFSET},
      {2'b00, `IDX_LOOP_ERROR}, {2'b00, `IDX_CYCLE_TIME}, {2'b00, `IDX_CONTROL},
      {2'b00, `IDX_STATUS}, {2'b00, `IDX_SETPOINT}, {2'b00, `IDX_PROCESS},
      {2'b00, `IDX_MANUAL_CV}, {2'b00, `IDX_CONTROL_VALUE}:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      deadband_value      <= 16'h0000;
      setpoint_low_limit  <= 16'h0000;
      setpoint_high_limit <= 16'h0000;
      control_low_limit   <= `RST_CV_LOW;
      control_high_limit  <= `RST_CV_HIGH;
      control_offset      <= 16'h0000;
      pulse_cycle_time    <= 16'h0000;
      setpoint_value      <= 16'h0000;
      process_value       <= 16'h0000;
      manual_value        <= 12'h000;
      auto_mode           <= 1'b0;
      pulse_enable        <= 1'b0;
    end
    else if (wr_en && addr_ok)
    begin
      case (word_index)
        {2'b00, `IDX_DEADBAND}:  deadband_value      <= pwdata[15:0];
        {2'b00, `IDX_SP_LOW}:    setpoint_low_limit  <= pwdata[15:0];
        {2'b00, `IDX_SP_HIGH}:   setpoint_high_limit <= pwdata[15:0];
        {2'b00, `IDX_CV_LOW}:    control_low_limit   <= pwdata[15:0];
        {2'b00, `IDX_CV_HIGH}:   control_high_limit  <= pwdata[15:0];
        {2'b00, `IDX_CV_OFFSET}: control_offset      <= pwdata[15:0];
        {2'b00, `IDX_CYCLE_TIME}: pulse_cycle_time   <= pwdata[15:0];
        {2'b00, `IDX_SETPOINT}:  setpoint_value      <= pwdata[15:0];
        {2'b00, `IDX_PROCESS}:   process_value       <= pwdata[15:0];
        {2'b00, `IDX_MANUAL_CV}: manual_value        <= pwdata[11:0];
        {2'b00, `IDX_CONTROL}:
        begin
          auto_mode    <= pwdata[`CTRL_AUTO_BIT];
          pulse_enable <= pwdata[`CTRL_PULSE_EN_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    // An unaligned read is refused and answers zero, like an unmapped one.
    else if (psel && !penable && !pwrite && !addr_ok)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (word_index)
        {2'b00, `IDX_DEADBAND}:      prdata <= {16'h0000, deadband_value};
        {2'b00, `IDX_SP_LOW}:        prdata <= {16'h0000, setpoint_low_limit};
        {2'b00, `IDX_SP_HIGH}:       prdata <= {16'h0000, setpoint_high_limit};
        {2'b00, `IDX_CV_LOW}:        prdata <= {16'h0000, control_low_limit};
        {2'b00, `IDX_CV_HIGH}:       prdata <= {16'h0000, control_high_limit};
        {2'b00, `IDX_CV_OFFSET}:     prdata <= {16'h0000, control_offset};
        {2'b00, `IDX_LOOP_ERROR}:    prdata <= {16'h0000, loop_error};
        {2'b00, `IDX_CYCLE_TIME}:    prdata <= {16'h0000, pulse_cycle_time};
        {2'b00, `IDX_CONTROL}:       prdata <= {30'h00000000, pulse_enable, auto_mode};
        {2'b00, `IDX_STATUS}:        prdata <= {30'h00000000, pulse_out, saturated};
        {2'b00, `IDX_SETPOINT}:      prdata <= {16'h0000, setpoint_value};
        {2'b00, `IDX_PROCESS}:       prdata <= {16'h0000, process_value};
        {2'b00, `IDX_MANUAL_CV}:     prdata <= {20'h00000, manual_value};
        {2'b00, `IDX_CONTROL_VALUE}: prdata <= {20'h00000, control_value};
        default:                     prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Loop post-processing. Values are signed 16-bit; limits compare signed.

  reg  signed [15:0] sp_clamped;
  reg  signed [15:0] raw_error;
  reg  signed [15:0] abs_error;
  reg  signed [15:0] dead_error;
  reg  signed [17:0] cv_sum;
  reg  signed [17:0] cv_clamped;
  reg  signed [17:0] cv_ranged;

  always @*
  begin
    sp_clamped = setpoint_value;
    if ($signed(setpoint_value) < $signed(setpoint_low_limit))
      sp_clamped = setpoint_low_limit;
    if ($signed(setpoint_value) > $signed(setpoint_high_limit))
      sp_clamped = setpoint_high_limit;
    raw_error  = process_value - sp_clamped;
    abs_error  = raw_error[15] ? -raw_error : raw_error;
    // Compared as unsigned so -32768 counts as large, not negative.
    dead_error = ($unsigned(abs_error) < deadband_value) ? 16'sh0000 : raw_error;
    cv_sum     = {{2{computed_value[15]}}, computed_value} + {{2{control_offset[15]}}, control_offset};
    cv_clamped = cv_sum;
    if (cv_sum < $signed({{2{control_low_limit[15]}}, control_low_limit}))
      cv_clamped = {{2{control_low_limit[15]}}, control_low_limit};
    if (cv_sum > $signed({{2{control_high_limit[15]}}, control_high_limit}))
      cv_clamped = {{2{control_high_limit[15]}}, control_high_limit};
    // The output is 12 bits wide whatever the limits say.
    cv_ranged = cv_clamped;
    if (cv_clamped < 18'sh00000)
      cv_ranged = 18'sh00000;
    if (cv_clamped > 18'sh00fff)
      cv_ranged = 18'sh00fff;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_error     <= 16'h0000;
      loop_error_out <= 16'h0000;
      setpoint_used  <= 16'h0000;
      control_value  <= 12'h000;
      saturated      <= 1'b1;
    end
    else
    begin
      if (loop_update)
      begin
        loop_error     <= dead_error;
        loop_error_out <= dead_error;
        setpoint_used  <= sp_clamped;
      end
      if (!auto_mode)
        control_value <= manual_value;
      else if (loop_update)
        control_value <= cv_ranged[11:0];
      saturated <= (auto_mode ? (loop_update ? cv_ranged[11:0] : control_value) : manual_value) == 12'h000 ||
                   (auto_mode ? (loop_update ? cv_ranged[11:0] : control_value) : manual_value) == `CV_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse output on a tenth-second time base.

  wire tenth_tick;

  tick_divider #(
    .COUNT (TENTH_COUNT)
  ) tick_divider_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (~pulse_enable),
    .tick    (tenth_tick)
  );

  // A long cycle time is kinder to relay contacts; nothing here enforces it.
  pulse_generator pulse_generator_inst (
    .pclk          (pclk),
    .presetn       (presetn),
    .enable        (pulse_enable),
    .tenth_tick    (tenth_tick),
    .cycle_time    (pulse_cycle_time),
    .control_value (control_value),
    .pulse_out     (pulse_out)
  );

endmodule

//--- pid_limits_regs.vh
// Register offsets, field positions, reset values and timing counts of the loop limit and pulse output stage.
// Overview of operation
// - Error magnitude below deadband is treated as zero at each loop update.
// - Setpoint below its low limit is replaced by the low limit.
// - Setpoint above its high limit is replaced by the high limit.
// - In auto mode a control value below its low limit is raised to it; reset value zero.
// - In auto mode a control value above its high limit is capped; reset value 4095.
// - Constant offset is added, so zero error yields the offset.
// - Loop error is stored each update in a read-only status register.
// - Enabled output is on for control value over 4096 of each cycle.
// - With the pulse enable cleared the output stays off.
// - Pulse cycle time counts in tenths of a second.
// - In auto mode the low-limit clamp keeps on-time at least low limit over 4096 of cycle.
// - Saturation flag shows when control value is 0 or 4095.
// - Auto mode updates control value each sample; manual leaves operator value.
`ifndef PID_LIMITS_REGS_VH
`define PID_LIMITS_REGS_VH

// Printed offsets are word indices; byte address is four times the index.
`define IDX_DEADBAND        8'h05
`define IDX_SP_LOW          8'h06
`define IDX_SP_HIGH         8'h07
`define IDX_CV_LOW          8'h08
`define IDX_CV_HIGH         8'h09
`define IDX_CV_OFFSET       8'h0a
`define IDX_LOOP_ERROR      8'h0b
`define IDX_CYCLE_TIME      8'h0e
`define IDX_CONTROL         8'h10
`define IDX_STATUS          8'h11
`define IDX_SETPOINT        8'h12
`define IDX_PROCESS         8'h13
`define IDX_MANUAL_CV       8'h14
`define IDX_CONTROL_VALUE   8'h15

`define CTRL_AUTO_BIT       0
`define CTRL_PULSE_EN_BIT   1
`define STAT_SAT_BIT        0
`define STAT_OUT_BIT        1

`define RST_CV_LOW          16'h0000
`define RST_CV_HIGH         16'h0fff
`define CV_MAX              12'hfff
`define CV_SCALE_BITS       12

// One tenth of a second in ns, and the clock period in ns.
`define TENTH_SEC_NS        100000000
`define CLK_PERIOD_NS       4
`define TENTH_SEC_CYCLES    (`TENTH_SEC_NS / `CLK_PERIOD_NS)

`endif

//--- tick_divider.v
// Divider that produces a one-cycle enable pulse every count cycles.
`timescale 1ns/1ps
module tick_divider #(
  parameter integer COUNT = 25000000
) (
  input  wire pclk,
  input  wire presetn,
  input  wire clear,
  output reg  tick
);

  reg [31:0] count;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end
    else if (clear)
    begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end
    else if (count == COUNT - 1)
    begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end

endmodule

//--- pulse_generator.v
// Time-proportional pulse generator: on for control value over 4096 of each cycle.
`timescale 1ns/1ps
`include "pid_limits_regs.vh"
module pulse_generator (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        enable,
  input  wire        tenth_tick,
  input  wire [15:0] cycle_time,
  input  wire [11:0] control_value,
  output reg         pulse_out
);

  // Phase counts in 1/4096 steps of a tenth: each tenth adds 4096 phase units, so
  // on-time = control_value / 4096 * cycle without a divider.
  reg  [27:0] phase;
  reg  [27:0] phase_end;
  wire [27:0] next_phase;
  wire [27:0] on_limit;

  assign next_phase = phase + 28'h0001000;
  assign on_limit   = control_value * cycle_time;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase     <= 28'h0000000;
      phase_end <= 28'h0000000;
      pulse_out <= 1'b0;
    end
    else if (!enable)
    begin
      phase     <= 28'h0000000;
      phase_end <= 28'h0000000;
      pulse_out <= 1'b0;
    end
    else
    begin
      if (tenth_tick)
      begin
        if (phase == 28'h0000000 || next_phase >= phase_end)
        begin
          // New cycle: sample the length and restart
          phase     <= (phase == 28'h0000000) ? 28'h0001000 : 28'h0000000;
          phase_end <= {cycle_time, 12'h000};
        end
        else
        begin
          phase <= next_phase;
        end
      end
      // A zero cycle time keeps the output off rather than stuck on.
      pulse_out <= (cycle_time != 16'h0000) && (({phase[27:12], 12'h000}) < on_limit);
    end
  end

endmodule

//--- pid_limits_props.sv
// Port-level checker for the loop limit stage.
`timescale 1ns/1ps
module pid_limits_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        loop_update,
  input wire [15:0] loop_error_out,
  input wire [15:0] setpoint_used,
  input wire [11:0] control_value,
  input wire        saturated,
  input wire        pulse_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  // A change lands one edge after the strobe is sampled; the sequence still requires two quiet samples.
  sequence s_quiet;
    !loop_update ##1 !loop_update;
  endsequence
  property p_ready; s_access |-> pready; endproperty
  property p_unaligned; s_access ##0 (paddr[1:0] != 2'b00) |-> pslverr; endproperty
  property p_err_phase; pslverr |-> psel && penable; endproperty
  property p_refused_read; s_access ##0 (!pwrite && pslverr) |-> prdata == 32'h0; endproperty
  property p_sat; saturated == (control_value == 12'h000 || control_value == 12'hfff); endproperty
  property p_err_hold; s_quiet |=> $stable(loop_error_out); endproperty
  property p_setpoint_hold; s_quiet |=> $stable(setpoint_used); endproperty
  property p_pulse; pulse_out |-> $past(control_value) != 12'h000; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  a_refused_read: assert property (p_refused_read) else $error("refused read not zero");
  a_sat: assert property (p_sat) else $error("saturation flag wrong");
  a_err_hold: assert property (p_err_hold) else $error("error moved without update");
  a_setpoint_hold: assert property (p_setpoint_hold) else $error("setpoint moved without update");
  a_pulse: assert property (p_pulse) else $error("pulse with zero control value");
endmodule
bind pid_limits pid_limits_props pid_limits_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .loop_update(loop_update), .loop_error_out(loop_error_out), .setpoint_used(setpoint_used),
  .control_value(control_value), .saturated(saturated), .pulse_out(pulse_out));

//--- discrete_load.sv
// Load on the discrete output: counts the cycles it is driven on.
`timescale 1ns/1ps
module discrete_load (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        drive,
  output reg  [31:0] on_cycles
);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      on_cycles <= 32'h0;
    else if (drive)
      on_cycles <= on_cycles + 32'h1;
endmodule

//--- test_pid_limits.sv
// Self-checking bench for the loop limit stage.
`timescale 1ns/1ps
`include "pid_limits_regs.vh"
module test_pid_limits;
  reg         pclk, presetn, psel, penable, pwrite, loop_update;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd, base;
  reg  [15:0] computed_value;
  wire        pready, pslverr, saturated, pulse_out;
  wire [31:0] prdata, on_cycles;
  wire [15:0] loop_error_out, setpoint_used;
  wire [11:0] control_value;
  reg         re;
  integer     fails, compares, cycles;
  // A four-cycle tick stands in for the tenth second, so whole pulse cycles fit in the run.
  pid_limits #(.TENTH_COUNT(4)) pid_limits_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .loop_update(loop_update), .computed_value(computed_value), .loop_error_out(loop_error_out),
    .setpoint_used(setpoint_used), .control_value(control_value), .saturated(saturated),
    .pulse_out(pulse_out));
  discrete_load discrete_load_inst (.pclk(pclk), .presetn(presetn), .drive(pulse_out), .on_cycles(on_cycles));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function [11:0] ba(input [7:0] idx);
    ba = {2'b00, idx, 2'b00};
  endfunction
  task summarize;
  begin
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task upd(input [15:0] sp_in, input [15:0] c, input [15:0] e_sp, input [15:0] e_err, input [11:0] e_out);
  begin
    apb(1'b1, ba(`IDX_SETPOINT), {16'h0, sp_in});
    @(posedge pclk);
    loop_update <= 1'b1;
    computed_value <= c;
    @(posedge pclk);
    loop_update <= 1'b0;
    @(posedge pclk);
    #1;
    chk(setpoint_used, e_sp);
    chk(loop_error_out, e_err);
    chk(control_value, e_out);
    apb(1'b0, ba(`IDX_LOOP_ERROR), 32'h0);
    chk(rd, e_err);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_defaults;
  begin
    apb(1'b0, ba(`IDX_CV_LOW), 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ba(`IDX_CV_HIGH), 32'h0);
    chk(rd, 32'hfff);
    apb(1'b0, 12'h03c, 32'h0);
    chk({rd[30:0], re}, 32'h1);
    apb(1'b1, 12'h015, 32'h0);
    chk(re, 1'b1);
    apb(1'b0, ba(`IDX_CV_HIGH) | 12'h001, 32'h0);
    chk(rd, 32'h0);
    chk(re, 1'b1);
    $display("t_defaults done");
  end
  endtask
  task t_limits;
  begin
    apb(1'b1, ba(`IDX_DEADBAND), 32'h5);
    apb(1'b1, ba(`IDX_SP_LOW), 32'h64);
    apb(1'b1, ba(`IDX_SP_HIGH), 32'hc8);
    apb(1'b1, ba(`IDX_CV_LOW), 32'h1e);
    apb(1'b1, ba(`IDX_CV_HIGH), 32'h3e8);
    apb(1'b1, ba(`IDX_CV_OFFSET), 32'h32);
    apb(1'b1, ba(`IDX_PROCESS), 32'h96);
    apb(1'b1, ba(`IDX_CONTROL), 32'h1);
    apb(1'b0, ba(`IDX_DEADBAND), 32'h0);
    chk(rd, 32'h5);
    upd(16'h0032, 16'h0000, 16'h0064, 16'h0032, 12'h032);
    upd(16'h012c, 16'h07d0, 16'h00c8, 16'hffce, 12'h3e8);
    upd(16'h0094, 16'hfe70, 16'h0094, 16'h0000, 12'h01e);
    apb(1'b1, ba(`IDX_LOOP_ERROR), 32'h1234);
    apb(1'b0, ba(`IDX_LOOP_ERROR), 32'h0);
    chk(rd, 32'h0);
    $display("t_limits done");
  end
  endtask
  task t_sat;
  begin
    apb(1'b1, ba(`IDX_CV_LOW), 32'h0);
    apb(1'b1, ba(`IDX_CV_HIGH), 32'hfff);
    upd(16'h0094, 16'h1388, 16'h0094, 16'h0000, 12'hfff);
    chk(saturated, 1'b1);
    upd(16'h0094, 16'hff00, 16'h0094, 16'h0000, 12'h000);
    chk(saturated, 1'b1);
    $display("t_sat done");
  end
  endtask
  task t_manual;
  begin
    apb(1'b1, ba(`IDX_CONTROL), 32'h0);
    apb(1'b1, ba(`IDX_MANUAL_CV), 32'h123);
    @(posedge pclk);
    loop_update <= 1'b1;
    computed_value <= 16'h0400;
    @(posedge pclk);
    loop_update <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(control_value, 12'h123);
    chk(saturated, 1'b0);
    $display("t_manual done");
  end
  endtask
  task t_pulse;
  begin
    // A long cycle suits relay loads; 50 tenths of four-cycle ticks make a 200-clock cycle.
    apb(1'b1, ba(`IDX_CYCLE_TIME), 32'h32);
    apb(1'b0, ba(`IDX_CYCLE_TIME), 32'h0);
    chk(rd, 32'h32);
    repeat (200) @(posedge pclk);
    chk(on_cycles, 32'h0);
    apb(1'b1, ba(`IDX_MANUAL_CV), 32'h800);
    apb(1'b1, ba(`IDX_CONTROL), 32'h2);
    repeat (300) @(posedge pclk);
    #1;
    base = on_cycles;
    repeat (200) @(posedge pclk);
    #1;
    chk(on_cycles - base, 32'h64);
    apb(1'b1, ba(`IDX_CONTROL), 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    base = on_cycles;
    repeat (200) @(posedge pclk);
    #1;
    chk(on_cycles - base, 32'h0);
    chk(pulse_out, 1'b0);
    $display("t_pulse done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    loop_update = 1'b0;
    computed_value = 16'h0;
    fails = 0;
    compares = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults;
    t_limits;
    t_sat;
    t_manual;
    t_pulse;
    summarize;
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      summarize;
    end
  end
endmodule
